// File: fpwm_fan_drive.sv
// pwm fan driver with drive ramping, tach settings and temperature limit checking
`timescale 1ns/1ns
`include "fpwm_params.svh"

// Behaviour
// - output type bit: open drain or push-pull
// - normal polarity: 00h off, FFh full on
// - inverted polarity swaps the duty cycle
// - base field picks one of four frequencies
// - reading at or above high limit flags
// - reading below low limit flags
// - four signed high and low limits
// - software lock blocks limit writes
// - drive register reads back applied drive
// - writes dropped while loop or table active
// - manual mode: write sets drive directly
// - duty equals drive over 255
// - divider lowers frequency, keeps duty
// - divide value zero acts as one
// - loop enable selects automatic drive
// - table lock forces loop enable bit
// - range field scales tach counts
// - edges field sets edges per rotation
// - update field sets drive update interval
// - one bounded drive step per update
// - status read clears only vanished conditions
// - channel enable gates alert, not status
module fpwm_fan_drive #(
   parameter logic [31:0] UPDATE_UNIT_CYCLES = `FPWM_UPDATE_UNIT_CYC
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_resetn,
   // register port
   input wire fpwm_pkg::fpwm_reg_req_t i_reg,
   output logic [7:0] o_reg_rdata,
   // measurements, index 0 internal, 1 to 3 external
   input wire logic [3:0][7:0] i_temp,
   // speed loop, lookup table and software lock
   input wire logic [7:0] i_loop_drive,
   input wire logic [7:0] i_table_drive,
   input wire logic i_table_active,
   input wire logic i_table_lock,
   input wire logic i_table_rpm_mode,
   input wire logic [7:0] i_fan_step,
   input wire logic i_soft_lock,
   // fan pin and status outputs
   output logic o_pwm_out,
   output logic o_pwm_oe_n,
   output logic o_alert_n,
   output logic o_update_tick,
   output fpwm_pkg::fpwm_tach_cfg_t o_tach_cfg
);

   // register state
   logic [7:0] output_config;
   logic [7:0] base_freq;
   logic [7:0] pwm_divider;
   logic [7:0] loop_config;
   logic [7:0] drive;
   logic [3:0][7:0] high_limit;
   logic [3:0][7:0] low_limit;
   logic [3:0] high_status;
   logic [3:0] low_status;
   logic [3:0] chan_enable;

   // pwm state
   logic [17:0] pre_count;
   logic [7:0] step;
   logic [7:0] duty_live;
   logic [7:0] div_live;
   logic [1:0] base_live;

   // update interval state
   logic [31:0] unit_count;
   logic [4:0] unit_index;

   // register access decode
   wire wr = i_reg.write;
   wire rd = i_reg.read;
   wire [7:0] addr = i_reg.addr;
   wire [7:0] wdata = i_reg.wdata;
   wire wr_output_config = wr && (addr == `FPWM_ADDR_OUTPUT_CONFIG);
   wire wr_base_freq = wr && (addr == `FPWM_ADDR_BASE_FREQ);
   wire wr_divider = wr && (addr == `FPWM_ADDR_DIVIDER);
   wire wr_loop_config = wr && (addr == `FPWM_ADDR_LOOP_CONFIG);
   wire wr_chan_enable = wr && (addr == `FPWM_ADDR_CHAN_ENABLE);
   wire rd_high_status = rd && (addr == `FPWM_ADDR_HIGH_STATUS);
   wire rd_low_status = rd && (addr == `FPWM_ADDR_LOW_STATUS);

   // drive source selection
   wire loop_on = loop_config[`FPWM_BIT_LOOP_EN];
   wire auto_on = loop_on || i_table_active;
   wire wr_drive = wr && (addr == `FPWM_ADDR_DRIVE) && !auto_on;
   wire [7:0] auto_target = loop_on ? i_loop_drive : i_table_drive;

   // limit addresses per channel
   wire [3:0][7:0] high_addr = {`FPWM_ADDR_EXT3_HIGH, `FPWM_ADDR_EXT2_HIGH,
                                `FPWM_ADDR_EXT1_HIGH, `FPWM_ADDR_INT_HIGH};
   wire [3:0][7:0] low_addr = {`FPWM_ADDR_EXT3_LOW, `FPWM_ADDR_EXT2_LOW,
                               `FPWM_ADDR_EXT1_LOW, `FPWM_ADDR_INT_LOW};

   // per-channel limit logic
   logic [3:0] high_cond;
   logic [3:0] low_cond;
   logic [3:0] high_hit;
   logic [3:0] low_hit;
   logic [3:0] wr_high;
   logic [3:0] wr_low;

   genvar ch;
   generate
      for (ch = 0; ch < 4; ch = ch + 1)
      begin : g_chan
         assign wr_high[ch] = wr && (addr == high_addr[ch]) && !i_soft_lock;
         assign wr_low[ch] = wr && (addr == low_addr[ch]) && !i_soft_lock;
         assign high_cond[ch] = $signed(i_temp[ch]) >= $signed(high_limit[ch]);
         assign low_cond[ch] = $signed(i_temp[ch]) < $signed(low_limit[ch]);
         assign high_hit[ch] = (addr == high_addr[ch]);
         assign low_hit[ch] = (addr == low_addr[ch]);

         always_ff @(posedge i_clock or negedge i_resetn)
         begin
            if (!i_resetn)
            begin
               high_limit[ch] <= `FPWM_RST_HIGH_LIMIT;
               low_limit[ch] <= `FPWM_RST_LOW_LIMIT;
            end
            else
            begin
               if (wr_high[ch])
                  high_limit[ch] <= wdata;
               if (wr_low[ch])
                  low_limit[ch] <= wdata;
            end
         end
      end
   endgenerate

   // sticky status: a live condition always wins over the read clear
   wire [3:0] next_high_status = high_cond | (high_status & ~{4{rd_high_status}});
   wire [3:0] next_low_status = low_cond | (low_status & ~{4{rd_low_status}});
   wire next_alert_n = ~|((high_status | low_status) & chan_enable);

   // configuration fields
   wire next_loop_en = i_table_lock ? i_table_rpm_mode : wdata[`FPWM_BIT_LOOP_EN];
   wire [7:0] next_loop_config = {next_loop_en, wdata[`FPWM_BIT_LOOP_EN-1:0]};
   wire [1:0] range_code = loop_config[`FPWM_RANGE_HI:`FPWM_RANGE_LO];
   wire [1:0] edges_code = loop_config[`FPWM_EDGES_HI:`FPWM_EDGES_LO];
   wire [2:0] update_code = loop_config[`FPWM_UPDATE_HI:`FPWM_UPDATE_LO];

   // tach scaling: multiplier 1,2,4,8; edges 3,5,7,9
   wire [3:0] tach_mult = 4'(4'h1 << range_code);
   wire [3:0] tach_edges = {1'b0, edges_code, 1'b1} + 4'h2;

   // update interval in units of the base time
   logic [4:0] update_units;
   always_comb
   begin
      case (update_code)
         3'h0: update_units = 5'h01;
         3'h1: update_units = 5'h02;
         3'h2: update_units = 5'h03;
         3'h3: update_units = 5'h04;
         3'h4: update_units = 5'h05;
         3'h5: update_units = 5'h08;
         3'h6: update_units = 5'h0c;
         default: update_units = 5'h10;
      endcase
   end

   wire unit_done = (unit_count == UPDATE_UNIT_CYCLES - 32'h0000_0001);
   wire update_now = unit_done && (unit_index >= update_units - 5'h01);

   // ramped drive toward the automatic target
   wire [7:0] gap_up = auto_target - drive;
   wire [7:0] gap_down = drive - auto_target;
   logic [7:0] ramp_drive;
   always_comb
   begin
      if (auto_target > drive)
         ramp_drive = (gap_up > i_fan_step) ? drive + i_fan_step : auto_target;
      else
         ramp_drive = (gap_down > i_fan_step) ? drive - i_fan_step : auto_target;
   end

   logic [7:0] next_drive;
   always_comb
   begin
      if (wr_drive)
         next_drive = wdata;
      else if (auto_on && update_now)
         next_drive = ramp_drive;
      else
         next_drive = drive;
   end

   // pwm step timing from base frequency and divider
   logic [17:0] base_step_cyc;
   always_comb
   begin
      case (base_live)
         2'h0: base_step_cyc = `FPWM_STEP_CYC(`FPWM_BASE0_MHZ);
         2'h1: base_step_cyc = `FPWM_STEP_CYC(`FPWM_BASE1_MHZ);
         2'h2: base_step_cyc = `FPWM_STEP_CYC(`FPWM_BASE2_MHZ);
         default: base_step_cyc = `FPWM_STEP_CYC(`FPWM_BASE3_MHZ);
      endcase
   end

   wire [7:0] div_eff = (div_live == 8'h00) ? 8'h01 : div_live;
   wire [25:0] step_cyc = {8'h00, base_step_cyc} * {18'h0_0000, div_eff};
   wire step_done = ({8'h00, pre_count} + 26'h000_0001 >= step_cyc);
   wire period_end = step_done && (step == `FPWM_LAST_STEP);
   wire pwm_level = (step < duty_live) ^ output_config[`FPWM_BIT_INVERT];
   wire push_pull = output_config[`FPWM_BIT_OUTPUT_TYPE];
   wire next_pwm_out = push_pull ? pwm_level : 1'b0;
   wire next_pwm_oe_n = push_pull ? 1'b0 : pwm_level;

   // readback mux
   logic [7:0] next_rdata;
   always_comb
   begin
      next_rdata = 8'h00;
      case (addr)
         `FPWM_ADDR_HIGH_STATUS: next_rdata = {4'h0, high_status};
         `FPWM_ADDR_LOW_STATUS: next_rdata = {4'h0, low_status};
         `FPWM_ADDR_CHAN_ENABLE: next_rdata = {4'h0, chan_enable};
         `FPWM_ADDR_OUTPUT_CONFIG: next_rdata = output_config;
         `FPWM_ADDR_BASE_FREQ: next_rdata = base_freq;
         `FPWM_ADDR_DRIVE: next_rdata = drive;
         `FPWM_ADDR_DIVIDER: next_rdata = pwm_divider;
         `FPWM_ADDR_LOOP_CONFIG: next_rdata = loop_config;
         default:
         begin
            for (int i = 0; i < 4; i++)
            begin
               if (high_hit[i])
                  next_rdata = high_limit[i];
               if (low_hit[i])
                  next_rdata = low_limit[i];
            end
         end
      endcase
   end

   // configuration registers
   always_ff @(posedge i_clock or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         output_config <= `FPWM_RST_OUTPUT_CONFIG;
         base_freq <= `FPWM_RST_BASE_FREQ;
         pwm_divider <= `FPWM_RST_DIVIDER;
         chan_enable <= `FPWM_RST_CHAN;
      end
      else
      begin
         if (wr_output_config)
            output_config <= wdata & `FPWM_MASK_OUTPUT_CONFIG;
         if (wr_base_freq)
            base_freq <= wdata & `FPWM_MASK_BASE_FREQ;
         if (wr_divider)
            pwm_divider <= wdata;
         if (wr_chan_enable)
            chan_enable <= 4'(wdata & `FPWM_MASK_CHAN);
      end
   end

   // speed loop configuration, loop enable forced while the table lock holds
   always_ff @(posedge i_clock or negedge i_resetn)
   begin
      if (!i_resetn)
         loop_config <= `FPWM_RST_LOOP_CONFIG;
      else if (wr_loop_config)
         loop_config <= next_loop_config;
      else if (i_table_lock)
         loop_config[`FPWM_BIT_LOOP_EN] <= i_table_rpm_mode;
   end

   // applied drive
   always_ff @(posedge i_clock or negedge i_resetn)
   begin
      if (!i_resetn)
         drive <= `FPWM_RST_DRIVE;
      else
         drive <= next_drive;
   end

   // status and alert
   always_ff @(posedge i_clock or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         high_status <= 4'h0;
         low_status <= 4'h0;
         o_alert_n <= 1'b1;
      end
      else
      begin
         high_status <= next_high_status;
         low_status <= next_low_status;
         o_alert_n <= next_alert_n;
      end
   end

   // update interval timer
   always_ff @(posedge i_clock or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         unit_count <= 32'h0000_0000;
         unit_index <= 5'h00;
         o_update_tick <= 1'b0;
      end
      else
      begin
         unit_count <= unit_done ? 32'h0000_0000 : unit_count + 32'h0000_0001;
         if (update_now)
            unit_index <= 5'h00;
         else if (unit_done)
            unit_index <= unit_index + 5'h01;
         o_update_tick <= update_now;
      end
   end

   // pwm counters; new duty, divider and base load only at a period boundary
   always_ff @(posedge i_clock or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         pre_count <= 18'h0_0000;
         step <= 8'h00;
         duty_live <= `FPWM_RST_DRIVE;
         div_live <= `FPWM_RST_DIVIDER;
         base_live <= 2'(`FPWM_RST_BASE_FREQ);
      end
      else
      begin
         pre_count <= step_done ? 18'h0_0000 : pre_count + 18'h0_0001;
         if (step_done)
            step <= period_end ? 8'h00 : step + 8'h01;
         if (period_end)
         begin
            duty_live <= drive;
            div_live <= pwm_divider;
            base_live <= base_freq[1:0];
         end
      end
   end

   // pin, tach and readback outputs
   always_ff @(posedge i_clock or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_pwm_out <= 1'b0;
         o_pwm_oe_n <= 1'b1;
         o_reg_rdata <= 8'h00;
         o_tach_cfg <= '0;
      end
      else
      begin
         o_pwm_out <= next_pwm_out;
         o_pwm_oe_n <= next_pwm_oe_n;
         o_reg_rdata <= next_rdata;
         o_tach_cfg <= '{multiplier: tach_mult, edges: tach_edges, update_code: update_code};
      end
   end

endmodule

// File: fpwm_params.svh
// register offsets, field positions, reset values and timing constants of the fan drive block
`ifndef FPWM_PARAMS_SVH
`define FPWM_PARAMS_SVH

// register offsets
`define FPWM_ADDR_HIGH_STATUS 8'h24
`define FPWM_ADDR_LOW_STATUS 8'h25
`define FPWM_ADDR_CHAN_ENABLE 8'h28
`define FPWM_ADDR_OUTPUT_CONFIG 8'h2a
`define FPWM_ADDR_BASE_FREQ 8'h2b
`define FPWM_ADDR_EXT1_HIGH 8'h30
`define FPWM_ADDR_EXT2_HIGH 8'h31
`define FPWM_ADDR_EXT3_HIGH 8'h32
`define FPWM_ADDR_INT_HIGH 8'h34
`define FPWM_ADDR_EXT1_LOW 8'h38
`define FPWM_ADDR_EXT2_LOW 8'h39
`define FPWM_ADDR_EXT3_LOW 8'h3a
`define FPWM_ADDR_INT_LOW 8'h3c
`define FPWM_ADDR_DRIVE 8'h40
`define FPWM_ADDR_DIVIDER 8'h41
`define FPWM_ADDR_LOOP_CONFIG 8'h42

// field positions
`define FPWM_BIT_OUTPUT_TYPE 4
`define FPWM_BIT_INVERT 0
`define FPWM_BIT_LOOP_EN 7
`define FPWM_RANGE_HI 6
`define FPWM_RANGE_LO 5
`define FPWM_EDGES_HI 4
`define FPWM_EDGES_LO 3
`define FPWM_UPDATE_HI 2
`define FPWM_UPDATE_LO 0

// writable bit masks
`define FPWM_MASK_OUTPUT_CONFIG 8'h11
`define FPWM_MASK_BASE_FREQ 8'h03
`define FPWM_MASK_CHAN 8'h0f

// reset values
`define FPWM_RST_OUTPUT_CONFIG 8'h00
`define FPWM_RST_BASE_FREQ 8'h03
`define FPWM_RST_HIGH_LIMIT 8'h55
`define FPWM_RST_LOW_LIMIT 8'h00
`define FPWM_RST_DRIVE 8'h00
`define FPWM_RST_DIVIDER 8'h01
`define FPWM_RST_LOOP_CONFIG 8'h2b
`define FPWM_RST_CHAN 4'h0

// pwm timing: clock in hertz, base frequencies in millihertz, 255 steps per period
`define FPWM_CLOCK_HZ 64'd250000000
`define FPWM_STEPS 8'hff
`define FPWM_LAST_STEP 8'hfe
`define FPWM_BASE0_MHZ 64'd26000000
`define FPWM_BASE1_MHZ 64'd19531000
`define FPWM_BASE2_MHZ 64'd4882000
`define FPWM_BASE3_MHZ 64'd2441000
`define FPWM_STEP_CYC(f) (18'((`FPWM_CLOCK_HZ * 64'd1000) / ((f) * 64'd255)))

// update interval unit
`define FPWM_UPDATE_UNIT_MS 64'd100
`define FPWM_UPDATE_UNIT_CYC (32'((`FPWM_CLOCK_HZ * `FPWM_UPDATE_UNIT_MS) / 64'd1000))

`endif

// File: fpwm_pkg.sv
// types shared by the fan drive block
package fpwm_pkg;

   typedef struct packed {
      logic       write;
      logic       read;
      logic [7:0] addr;
      logic [7:0] wdata;
   } fpwm_reg_req_t;

   typedef struct packed {
      logic [3:0] multiplier;
      logic [3:0] edges;
      logic [2:0] update_code;
   } fpwm_tach_cfg_t;

endpackage

// File: fpwm_fan_model.sv
// behavioural 4-wire fan: samples the pwm wire and counts its high cycles
`timescale 1ns/1ns
module fpwm_fan_model (
   // clock and pwm wire
   input wire logic i_clock,
   input wire logic i_pwm,
   // measurement control and results
   input wire logic i_clear,
   output logic [31:0] o_high_count,
   output logic o_rise
);
   logic pwm_q;
   always @(posedge i_clock)
   begin
      pwm_q <= i_pwm;
      o_rise <= i_pwm && !pwm_q;
      o_high_count <= i_clear ? 32'h0000_0000 : o_high_count + {31'h0, i_pwm};
   end
endmodule

// File: fpwm_fan_drive_chk.sv
// port checks for the fan drive block
`timescale 1ns/1ns
module fpwm_fan_drive_chk (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_resetn,
   // register port and inputs
   input wire fpwm_pkg::fpwm_reg_req_t i_reg,
   input wire logic [7:0] o_reg_rdata,
   input wire logic [3:0][7:0] i_temp,
   input wire logic i_soft_lock,
   // outputs
   input wire logic o_pwm_out,
   input wire logic o_pwm_oe_n,
   input wire logic o_alert_n,
   input wire logic o_update_tick,
   input wire fpwm_pkg::fpwm_tach_cfg_t o_tach_cfg
);
   logic [7:0] hi1, lo2, cfg;
   logic [3:0] en;
   logic [1:0] age;
   wire wr_ok = i_reg.write && !i_soft_lock;
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_resetn);
   // shadows of the registers the checks depend on
   always_ff @(posedge i_clock or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         hi1 <= 8'h55;
         lo2 <= 8'h00;
         cfg <= 8'h2b;
         en <= 4'h0;
         age <= 2'h0;
      end
      else
      begin
         if (wr_ok && i_reg.addr == 8'h30)
            hi1 <= i_reg.wdata;
         if (wr_ok && i_reg.addr == 8'h39)
            lo2 <= i_reg.wdata;
         if (i_reg.write && i_reg.addr == 8'h42)
            cfg <= i_reg.wdata;
         if (i_reg.write && i_reg.addr == 8'h28)
            en <= i_reg.wdata[3:0];
         if (age != 2'h3)
            age <= age + 2'h1;
      end
   end
   sequence s_high_held;
      (en[1] && $signed(i_temp[1]) >= $signed(hi1)) [*4];
   endsequence
   sequence s_low_held;
      (en[2] && $signed(i_temp[2]) < $signed(lo2)) [*4];
   endsequence
   sequence s_cfg_steady;
      age == 2'h3 && $stable(cfg) && $past(cfg) == $past(cfg, 2);
   endsequence
   chk_alert_high_limit: assert property (s_high_held |-> !o_alert_n)
      else $error("alert missing for high reading");
   chk_alert_low_limit: assert property (s_low_held |-> !o_alert_n)
      else $error("alert missing for low reading");
   chk_alert_all_masked: assert property (en == 4'h0 && $past(en) == 4'h0 |-> o_alert_n)
      else $error("alert raised with all channels masked");
   chk_limit_lock_readback: assert property (i_reg.addr == 8'h30 |=> o_reg_rdata == $past(hi1))
      else $error("high limit readback wrong");
   chk_tach_range_scale: assert property (s_cfg_steady |-> o_tach_cfg.multiplier == 4'h1 << cfg[6:5])
      else $error("tach multiplier wrong");
   chk_tach_edge_count: assert property (s_cfg_steady |-> o_tach_cfg.edges == 4'h3 + {1'b0, cfg[4:3], 1'b0})
      else $error("tach edge count wrong");
   chk_update_tick_pulse: assert property (o_update_tick |=> (!o_update_tick) [*8])
      else $error("update ticks too close");
   chk_released_pin_low: assert property (o_pwm_oe_n |-> !o_pwm_out)
      else $error("pwm data high while pin released");
endmodule
bind fpwm_fan_drive fpwm_fan_drive_chk chk_u (.i_clock(i_clock), .i_resetn(i_resetn),
   .i_reg(i_reg), .o_reg_rdata(o_reg_rdata), .i_temp(i_temp), .i_soft_lock(i_soft_lock),
   .o_pwm_out(o_pwm_out), .o_pwm_oe_n(o_pwm_oe_n), .o_alert_n(o_alert_n),
   .o_update_tick(o_update_tick), .o_tach_cfg(o_tach_cfg));

// File: fpwm_testbench.sv
// self-checking bench for the fan drive block
`timescale 1ns/1ns
module testbench;
   // step length of base code 0 in clock cycles
   localparam logic [31:0] STEP0 = 32'h0000_0025;
   logic i_clock;
   logic i_resetn;
   fpwm_pkg::fpwm_reg_req_t req;
   logic [3:0][7:0] temp;
   logic [7:0] loop_drive, table_drive, fan_step, rdata, got;
   logic table_lock, table_active, rpm_mode, soft_lock, clear;
   logic pwm_out, pwm_oe_n, alert_n, tick, rise;
   logic [31:0] high_count;
   fpwm_pkg::fpwm_tach_cfg_t tach;
   // pull-up on the fan's pwm input
   wire pwm_pin = pwm_oe_n ? 1'b1 : pwm_out;
   int bad_count = 0;
   int n_checks = 0;
   int cycles = 0;
   logic [15:0] rst_tab [17] = '{16'h2a00, 16'h2b03, 16'h3055, 16'h3155, 16'h3255, 16'h3455,
      16'h3800, 16'h3900, 16'h3a00, 16'h3c00, 16'h4000, 16'h4101, 16'h422b, 16'h2400,
      16'h2500, 16'h2800, 16'h5000};
   fpwm_fan_drive #(.UPDATE_UNIT_CYCLES(32'h0000_0014)) dut_u (.i_clock(i_clock),
      .i_resetn(i_resetn), .i_reg(req), .o_reg_rdata(rdata), .i_temp(temp),
      .i_loop_drive(loop_drive), .i_table_drive(table_drive), .i_table_active(table_active),
      .i_table_lock(table_lock), .i_table_rpm_mode(rpm_mode), .i_fan_step(fan_step),
      .i_soft_lock(soft_lock), .o_pwm_out(pwm_out), .o_pwm_oe_n(pwm_oe_n),
      .o_alert_n(alert_n), .o_update_tick(tick), .o_tach_cfg(tach));
   fpwm_fan_model fan_u (.i_clock(i_clock), .i_pwm(pwm_pin), .i_clear(clear),
      .o_high_count(high_count), .o_rise(rise));
   initial
   begin
      i_clock = 1'b0;
      forever #2 i_clock = ~i_clock;
   end
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   always @(posedge i_clock)
   begin
      cycles <= cycles + 1;
      if (cycles == 150000)
      begin
         bad_count = bad_count + 1;
         finish_test();
      end
   end
   task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] val);
      n_checks = n_checks + 1;
      if (val !== exp)
      begin
         bad_count = bad_count + 1;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, val);
      end
   endtask
   task automatic chk32(input string name, input logic [31:0] exp, input logic [31:0] val);
      n_checks = n_checks + 1;
      if (val !== exp)
      begin
         bad_count = bad_count + 1;
         $display("CHECK FAILED %s expected %0d seen %0d", name, exp, val);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clock);
      req <= '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
      @(posedge i_clock);
      req.write <= 1'b0;
   endtask
   // clr pulses the read strobe, which clears vanished status
   task automatic rd(input logic [7:0] a, input logic clr);
      @(posedge i_clock);
      req.addr <= a;
      req.read <= clr;
      @(posedge i_clock);
      req.read <= 1'b0;
      #1 got = rdata;
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] exp);
      rd(a, 1'b0);
      chk8($sformatf("reg %h", a), exp, got);
   endtask
   task automatic wait_ticks(input int n);
      repeat (n)
      begin
         @(posedge i_clock);
         while (tick !== 1'b1)
            @(posedge i_clock);
      end
   endtask
   task automatic measure(input logic [31:0] w, input logic [31:0] exp, input string name);
      @(posedge i_clock);
      clear <= 1'b1;
      @(posedge i_clock);
      clear <= 1'b0;
      repeat (w) @(posedge i_clock);
      #1 chk32(name, exp, high_count);
   endtask
   initial
   begin
      i_resetn = 1'b0;
      req = '0;
      temp = {4{8'h20}};
      // speed loop output for a tach target the host has already scaled
      loop_drive = 8'h90;
      table_drive = 8'h40;
      table_active = 1'b0;
      fan_step = 8'h08;
      table_lock = 1'b0;
      rpm_mode = 1'b0;
      soft_lock = 1'b0;
      clear = 1'b0;
      repeat (6) @(posedge i_clock);
      i_resetn <= 1'b1;
      foreach (rst_tab[i]) rc(rst_tab[i][15:8], rst_tab[i][7:0]);
      wr(8'h2b, 8'h00);
      wr(8'h2a, 8'hee);
      rc(8'h2a, 8'h00);
      wr(8'h30, 8'h40);
      rc(8'h30, 8'h40);
      @(posedge i_clock) soft_lock <= 1'b1;
      wr(8'h30, 8'h10);
      rc(8'h30, 8'h40);
      @(posedge i_clock) soft_lock <= 1'b0;
      $display("test registers done");
      @(posedge i_clock) temp[1] <= 8'h40;
      repeat (4) @(posedge i_clock);
      rc(8'h24, 8'h02);
      chk8("alert", 8'h01, 8'(alert_n));
      wr(8'h28, 8'h06);
      repeat (4) @(posedge i_clock);
      #1 chk8("alert", 8'h00, 8'(alert_n));
      rd(8'h24, 1'b1);
      rc(8'h24, 8'h02);
      @(posedge i_clock) temp[1] <= 8'h20;
      repeat (2) @(posedge i_clock);
      rd(8'h24, 1'b1);
      rc(8'h24, 8'h00);
      @(posedge i_clock) temp[2] <= 8'hf0;
      repeat (4) @(posedge i_clock);
      rc(8'h25, 8'h04);
      @(posedge i_clock) temp[2] <= 8'h20;
      repeat (2) @(posedge i_clock);
      rd(8'h25, 1'b1);
      rc(8'h25, 8'h00);
      repeat (2) @(posedge i_clock);
      #1 chk8("alert", 8'h01, 8'(alert_n));
      $display("test limits done");
      for (int i = 0; i < 8; i++)
      begin
         wr(8'h42, {1'b0, i[1:0], i[1:0], i[2:0]});
         repeat (3) @(posedge i_clock);
         #1 chk8("mult", 8'h01 << i[1:0], 8'(tach.multiplier));
         chk8("edges", 8'(3 + 2 * i[1:0]), 8'(tach.edges));
         chk8("update", 8'(i), 8'(tach.update_code));
      end
      $display("test tach done");
      wr(8'h40, 8'h80);
      rc(8'h40, 8'h80);
      wr(8'h42, 8'h80);
      wr(8'h40, 8'h10);
      wait_ticks(3);
      rc(8'h40, 8'h90);
      // retarget right after a tick so that exactly two steps follow
      wait_ticks(1);
      loop_drive <= 8'hff;
      wait_ticks(2);
      rc(8'h40, 8'ha0);
      @(posedge i_clock) table_lock <= 1'b1;
      rc(8'h42, 8'h00);
      @(posedge i_clock) rpm_mode <= 1'b1;
      rc(8'h42, 8'h80);
      @(posedge i_clock) table_lock <= 1'b0;
      wr(8'h42, 8'h03);
      wr(8'h40, 8'h40);
      @(posedge i_clock) table_active <= 1'b1;
      wr(8'h40, 8'h10);
      rc(8'h40, 8'h40);
      @(posedge i_clock) table_active <= 1'b0;
      $display("test drive done");
      // the first period runs at the reset base, so duty zero is checked inside it
      wr(8'h40, 8'h00);
      wr(8'h2a, 8'h01);
      measure(32'd2000, 32'd2000, "duty zero inverted");
      wr(8'h2a, 8'h00);
      measure(32'd2000, 32'd0, "duty zero");
      wr(8'h41, 8'h00);
      wr(8'h40, 8'h80);
      @(posedge i_clock);
      while (rise !== 1'b1)
         @(posedge i_clock);
      measure(255 * STEP0, 128 * STEP0, "duty half");
      $display("test pwm done");
      finish_test();
   end
endmodule
